// [logic/wfr_regs.v]
// wake-up frame identifier and upper mask registers with frame matcher
`default_nettype none
`include "wfr_consts.vh"

module wfr_regs
(
  // clock and reset
  input  wire                      clk_sys_in,
  input  wire                      rstn_in,
  // device reset events
  input  wire                      soft_reset_in,
  input  wire                      restart_in,
  // register port from the serial interface decoder
  input  wire [`WFR_ADDR_W-1:0]    reg_addr_in,
  input  wire [`WFR_REG_W-1:0]     reg_wdata_in,
  input  wire                      reg_wr_in,
  input  wire                      reg_rd_in,
  output reg  [`WFR_REG_W-1:0]     reg_rdata_out,
  // configuration valid control
  input  wire                      config_valid_set_in,
  input  wire                      config_change_in,
  input  wire                      wake_event_in,
  output wire                      wake_config_valid_out,
  // lower mask bits 12..0 from the companion register
  input  wire [`WFR_ID_LOW_W-1:0]  id_mask_low_in,
  // received can frame
  input  wire                      rx_valid_in,
  input  wire [`WFR_ID_W-1:0]      rx_id_in,
  input  wire                      rx_rtr_in,
  input  wire                      rx_ide_in,
  // matcher result
  output wire                      wake_up_frame_match_out
);

  reg  [`WFR_REG_W-1:0] id_low_q;
  reg  [`WFR_REG_W-1:0] id_high_q;
  reg  [`WFR_REG_W-1:0] mask_high_q;
  reg                   cfg_valid_q;
  reg                   cfg_valid_d;
  reg  [`WFR_REG_W-1:0] rdata_d;
  reg  [`WFR_REG_W-1:0] id_low_d;
  reg  [`WFR_REG_W-1:0] id_high_d;
  reg  [`WFR_REG_W-1:0] mask_high_d;

  wire wr_low;
  wire wr_high;
  wire wr_mask;
  wire cfg_write;
  wire [`WFR_ID_W-1:0] exp_id;
  wire [`WFR_ID_W-1:0] cmp_en;

  // fields of the lower identifier register as the matcher sees them
  wire [`WFR_LOW_ID_HI_MSB-`WFR_LOW_ID_HI_LSB:0] exp_id_12_5;
  wire [`WFR_LOW_ID_LO_MSB-`WFR_LOW_ID_LO_LSB:0] exp_id_4_0;
  wire                                           exp_rtr;
  wire                                           exp_ide;

  assign wr_low  = reg_wr_in & (reg_addr_in == `WFR_ADDR_ID_LOW);
  assign wr_high = reg_wr_in & (reg_addr_in == `WFR_ADDR_ID_HIGH);
  assign wr_mask = reg_wr_in & (reg_addr_in == `WFR_ADDR_MASK_HIGH);
  assign cfg_write = wr_low | wr_high | wr_mask | config_change_in;

  // next values; soft reset beats a write in the same cycle, and restart
  // is deliberately not a term, so every stored bit survives it
  always @*
  begin
    id_low_d    = id_low_q;
    id_high_d   = id_high_q;
    mask_high_d = mask_high_q;
    if (soft_reset_in)
    begin
      id_low_d    = `WFR_REG_RESET;
      id_high_d   = `WFR_REG_RESET;
      mask_high_d = `WFR_REG_RESET;
    end
    else
    begin
      if (wr_low)
        id_low_d = reg_wdata_in & `WFR_ID_LOW_WMASK;
      if (wr_high)
        id_high_d = reg_wdata_in;
      if (wr_mask)
        mask_high_d = reg_wdata_in;
    end
  end

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      id_low_q <= `WFR_REG_RESET;
    else
      id_low_q <= id_low_d;
  end

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      id_high_q <= `WFR_REG_RESET;
    else
      id_high_q <= id_high_d;
  end

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      mask_high_q <= `WFR_REG_RESET;
    else
      mask_high_q <= mask_high_d;
  end

  // host set wins over a same-cycle write, event or match clear; soft reset still beats the set
  always @*
  begin
    cfg_valid_d = cfg_valid_q;
    if (cfg_write | wake_event_in | wake_up_frame_match_out)
      cfg_valid_d = 1'b0;
    if (config_valid_set_in)
      cfg_valid_d = 1'b1;
  end

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      cfg_valid_q <= 1'b0;
    else if (soft_reset_in)
      cfg_valid_q <= 1'b0;
    else
      cfg_valid_q <= cfg_valid_d;
  end

  assign wake_config_valid_out = cfg_valid_q;

  // read mux; unmapped addresses read zero
  always @*
  begin
    rdata_d = `WFR_REG_RESET;
    case (reg_addr_in)
      `WFR_ADDR_ID_LOW:
        rdata_d = id_low_q & `WFR_ID_LOW_WMASK;
      `WFR_ADDR_ID_HIGH:
        rdata_d = id_high_q;
      `WFR_ADDR_MASK_HIGH:
        rdata_d = mask_high_q;
      default:
        rdata_d = `WFR_REG_RESET;
    endcase
  end

  // read data is registered and held until the next read strobe;
  // soft reset leaves it alone so a pending answer is not lost
  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      reg_rdata_out <= `WFR_REG_RESET;
    else if (reg_rd_in)
      reg_rdata_out <= rdata_d;
  end

  assign exp_id_12_5 = id_low_q[`WFR_LOW_ID_HI_MSB:`WFR_LOW_ID_HI_LSB];
  assign exp_id_4_0  = id_low_q[`WFR_LOW_ID_LO_MSB:`WFR_LOW_ID_LO_LSB];
  assign exp_rtr     = id_low_q[`WFR_LOW_RTR_BIT];
  assign exp_ide     = id_low_q[`WFR_LOW_IDE_BIT];

  // assemble the full 29-bit expected identifier and compare enables
  assign exp_id = {id_high_q, exp_id_12_5, exp_id_4_0};
  assign cmp_en = {mask_high_q, id_mask_low_in};

  wfr_id_match u_match
  (
    .clk_sys_in  (clk_sys_in),
    .rstn_in     (rstn_in),
    .exp_id_in   (exp_id),
    .cmp_en_in   (cmp_en),
    .exp_rtr_in  (exp_rtr),
    .exp_ide_in  (exp_ide),
    .enable_in   (cfg_valid_q),
    .rx_valid_in (rx_valid_in),
    .rx_id_in    (rx_id_in),
    .rx_rtr_in   (rx_rtr_in),
    .rx_ide_in   (rx_ide_in),
    .match_out   (wake_up_frame_match_out)
  );

  // restart_in is accepted for completeness of the reset set only
  wire unused_restart;
  assign unused_restart = restart_in;

endmodule
`default_nettype wire

// [logic/wfr_consts.vh]
// constants for the wake-up frame identifier filter registers
`ifndef WFR_CONSTS_VH
`define WFR_CONSTS_VH

// register addresses on the serial register port
`define WFR_ADDR_W            7
`define WFR_ADDR_ID_HIGH      7'h32
`define WFR_ADDR_ID_LOW       7'h33
`define WFR_ADDR_MASK_HIGH    7'h34

// register geometry
`define WFR_REG_W             16
`define WFR_REG_RESET         16'h0000
`define WFR_ID_LOW_WMASK      16'hff7f

// fields of the lower identifier register
`define WFR_LOW_ID_HI_MSB     15
`define WFR_LOW_ID_HI_LSB     8
`define WFR_LOW_RSVD_BIT      7
`define WFR_LOW_ID_LO_MSB     6
`define WFR_LOW_ID_LO_LSB     2
`define WFR_LOW_RTR_BIT       1
`define WFR_LOW_IDE_BIT       0

// identifier layout
`define WFR_ID_W              29
`define WFR_ID_LOW_W          13
`define WFR_STD_ID_LSB        18

`endif

// [logic/wfr_id_match.v]
// masked comparison of a received can identifier against the wake-up frame
`default_nettype none
`include "wfr_consts.vh"

module wfr_id_match
(
  // clock and reset
  input  wire                      clk_sys_in,
  input  wire                      rstn_in,
  // expected frame and compare enables
  input  wire [`WFR_ID_W-1:0]      exp_id_in,
  input  wire [`WFR_ID_W-1:0]      cmp_en_in,
  input  wire                      exp_rtr_in,
  input  wire                      exp_ide_in,
  input  wire                      enable_in,
  // received frame
  input  wire                      rx_valid_in,
  input  wire [`WFR_ID_W-1:0]      rx_id_in,
  input  wire                      rx_rtr_in,
  input  wire                      rx_ide_in,
  // result
  output reg                       match_out
);

  wire [`WFR_ID_W-1:0] bit_ok;
  wire                 fmt_ok;

  genvar i;
  generate
    for (i = 0; i < `WFR_ID_W; i = i + 1)
    begin : g_bit
      assign bit_ok[i] = ~cmp_en_in[i] |
                         (~exp_ide_in & (i < `WFR_STD_ID_LSB)) |
                         (exp_id_in[i] == rx_id_in[i]);
    end
  endgenerate

  // frame type and format must always agree
  assign fmt_ok = (exp_rtr_in == rx_rtr_in) & (exp_ide_in == rx_ide_in);

  always @(posedge clk_sys_in or negedge rstn_in)
  begin
    if (!rstn_in)
      match_out <= 1'b0;
    else
      match_out <= enable_in & rx_valid_in & fmt_ok & (&bit_ok);
  end

endmodule
`default_nettype wire

// [bench/wfr_regs_assertions.sv]
// assertions on the wake frame filter register ports
`default_nettype none
module wfr_chk
(
  // clock and reset
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  // register port
  input wire logic        soft_reset_in,
  input wire logic        reg_wr_in,
  input wire logic        reg_rd_in,
  input wire logic [6:0]  reg_addr_in,
  input wire logic [15:0] reg_wdata_in,
  input wire logic [15:0] reg_rdata_out,
  // configuration valid
  input wire logic        config_valid_set_in,
  input wire logic        config_change_in,
  input wire logic        wake_event_in,
  input wire logic        wake_config_valid_out,
  // matcher
  input wire logic        rx_valid_in,
  input wire logic        wake_up_frame_match_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  // write then read back the same address
  sequence s_wr_rd(a);
    reg_wr_in && !soft_reset_in && reg_addr_in == a
      ##1 reg_rd_in && !reg_wr_in && !soft_reset_in && reg_addr_in == a;
  endsequence
  a_low_readback: assert property (s_wr_rd(7'h33) |=>
    reg_rdata_out == ($past(reg_wdata_in, 2) & 16'hff7f)) else $error("low readback");
  a_mask_readback: assert property (s_wr_rd(7'h34) |=>
    reg_rdata_out == $past(reg_wdata_in, 2)) else $error("mask readback");
  a_rsvd_zero: assert property (reg_rd_in && reg_addr_in == 7'h33 |=>
    !reg_rdata_out[7]) else $error("reserved set");
  a_soft_clear: assert property (soft_reset_in && !config_valid_set_in |=>
    !wake_config_valid_out) else $error("soft kept valid");
  a_valid_set: assert property (config_valid_set_in && !soft_reset_in |=>
    wake_config_valid_out) else $error("valid not set");
  a_write_clears: assert property (reg_wr_in && !config_valid_set_in &&
    reg_addr_in inside {7'h32, 7'h33, 7'h34} |=> !wake_config_valid_out) else $error("kept");
  a_match_cause: assert property (wake_up_frame_match_out |->
    $past(rx_valid_in) && $past(wake_config_valid_out)) else $error("stray match");
  a_wake_clears: assert property (wake_up_frame_match_out && !config_valid_set_in |=>
    !wake_config_valid_out) else $error("wake kept valid");
  a_event_clears: assert property ((config_change_in || wake_event_in) &&
    !config_valid_set_in |=> !wake_config_valid_out) else $error("event kept valid");
endmodule
bind wfr_regs wfr_chk u_chk (.clk_sys_in, .rstn_in, .soft_reset_in, .reg_wr_in, .reg_rd_in,
  .config_valid_set_in, .config_change_in, .wake_event_in, .wake_config_valid_out,
  .rx_valid_in, .wake_up_frame_match_out,
  .reg_addr_in, .reg_wdata_in, .reg_rdata_out);
`default_nettype wire

// [bench/wfr_host.sv]
// host model on the register port and config valid strobe
`default_nettype none
module wfr_host
(
  // register port toward the block
  input  wire logic        clk_sys_in,
  output var  logic        reg_wr_out = 1'h0,
  output var  logic        reg_rd_out = 1'h0,
  output var  logic [6:0]  reg_addr_out = 7'h00,
  output var  logic [15:0] reg_wdata_out = 16'h0000,
  // configuration valid strobe
  output var  logic        cfg_set_out = 1'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    reg_addr_out = a;
    reg_wdata_out = d;
    reg_wr_out = 1'h1;
    @(posedge clk_sys_in);
    #1 reg_wr_out = 1'h0;
    // released data inverted so a stale sample cannot pass
    reg_wdata_out = ~d;
  endtask
  task automatic rd(input logic [6:0] a);
    reg_addr_out = a;
    reg_rd_out = 1'h1;
    @(posedge clk_sys_in);
    #1 reg_rd_out = 1'h0;
    // one idle edge so back-to-back reads never retoggle the strobe
    @(posedge clk_sys_in);
    #1;
  endtask
  task automatic set_valid();
    cfg_set_out = 1'h1;
    @(posedge clk_sys_in);
    #1 cfg_set_out = 1'h0;
  endtask
endmodule
`default_nettype wire

// [bench/wfr_regs_tb_top.sv]
// self-checking bench for the wake frame filter registers
`default_nettype none
module wfr_regs_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_in = 1'h0, rstn_in = 1'h0, soft_reset_in = 1'h0, restart_in = 1'h0;
  logic        rx_valid_in = 1'h0, rx_ide_in = 1'h1;
  logic        config_change_in = 1'h0, wake_event_in = 1'h0, rx_rtr_in = 1'h1;
  logic [12:0] id_mask_low_in = 13'h1fff;
  logic [28:0] rx_id_in = 29'h0000_0000;
  wire logic        wr, rd, cfg_set, valid, match;
  wire logic [6:0]  addr;
  wire logic [15:0] wdata, rdata;
  int          errors = 0, checks_done = 0, cycles = 0;
  always #2 clk_sys_in = ~clk_sys_in;
  wfr_regs dut (.clk_sys_in, .rstn_in, .soft_reset_in, .restart_in, .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .config_valid_set_in(cfg_set), .config_change_in, .wake_event_in,
    .wake_config_valid_out(valid), .id_mask_low_in, .rx_valid_in, .rx_id_in,
    .rx_rtr_in, .rx_ide_in, .wake_up_frame_match_out(match));
  wfr_host host (.clk_sys_in, .reg_wr_out(wr), .reg_rd_out(rd), .cfg_set_out(cfg_set),
    .reg_addr_out(addr), .reg_wdata_out(wdata));
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [6:0] a, input logic [15:0] exp);
    host.rd(a);
    chk(rdata, exp);
  endtask
  task automatic frame(input logic [28:0] id, input logic ide, exp);
    host.set_valid();
    rx_id_in = id;
    rx_ide_in = ide;
    rx_valid_in = 1'h1;
    @(posedge clk_sys_in);
    #1 rx_valid_in = 1'h0;
    chk(16'(match), 16'(exp));
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // well under a hundred cycles suffice
  always @(posedge clk_sys_in)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      errors++;
      finish_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_sys_in);
    #1 rstn_in = 1'h1;
    rdchk(7'h33, 16'h0000);
    rdchk(7'h34, 16'h0000);
    host.wr(7'h33, 16'hffff);
    rdchk(7'h33, 16'hff7f);
    host.wr(7'h34, 16'ha5c3);
    rdchk(7'h34, 16'ha5c3);
    host.wr(7'h32, 16'h1234);
    rdchk(7'h32, 16'h1234);
    rdchk(7'h40, 16'h0000);
    $display("regs done");
    restart_in = 1'h1;
    @(posedge clk_sys_in);
    #1 restart_in = 1'h0;
    rdchk(7'h33, 16'hff7f);
    rdchk(7'h34, 16'ha5c3);
    $display("restart done");
    frame(29'h0246_9fff, 1'h1, 1'h1);
    frame(29'h1246_9fff, 1'h1, 1'h0);
    frame(29'h0246_1fff, 1'h1, 1'h1);
    frame(29'h0246_9fff, 1'h0, 1'h0);
    rx_rtr_in = 1'h0;
    frame(29'h0246_9fff, 1'h1, 1'h0);
    rx_rtr_in = 1'h1;
    id_mask_low_in = 13'h1ffe;
    frame(29'h0246_9ffe, 1'h1, 1'h1);
    id_mask_low_in = 13'h1fff;
    frame(29'h0246_9ffe, 1'h1, 1'h0);
    host.set_valid();
    host.wr(7'h33, 16'hfffe);
    chk(16'(valid), 16'h0000);
    frame(29'h0246_a000, 1'h0, 1'h1);
    $display("match done");
    host.set_valid();
    config_change_in = 1'h1;
    @(posedge clk_sys_in);
    #1 config_change_in = 1'h0;
    chk(16'(valid), 16'h0000);
    host.set_valid();
    wake_event_in = 1'h1;
    @(posedge clk_sys_in);
    #1 wake_event_in = 1'h0;
    chk(16'(valid), 16'h0000);
    host.set_valid();
    chk(16'(valid), 16'h0001);
    soft_reset_in = 1'h1;
    @(posedge clk_sys_in);
    #1 soft_reset_in = 1'h0;
    chk(16'(valid), 16'h0000);
    rdchk(7'h34, 16'h0000);
    rdchk(7'h33, 16'h0000);
    $display("soft reset done");
    host.wr(7'h34, 16'h5a3c);
    host.set_valid();
    rstn_in = 1'h0;
    @(posedge clk_sys_in);
    #1 rstn_in = 1'h1;
    chk(16'(valid), 16'h0000);
    rdchk(7'h34, 16'h0000);
    $display("power-on reset done");
    finish_test();
  end
endmodule
`default_nettype wire
